// file: design/uarch_error_record.v
// Operation
// - bits 4:0 carry the failing structure code
// - bits 7:5 carry the structure level, zero is first
// - bits 11:8 carry array code, zero means unknown
// - bits 15:12 carry access kind: 0 unknown, 1 read, 2 write
// - bits 21:16 carry way, bit 22 marks it valid
// - bits 39:32 carry set index, bit 23 marks it valid
// - bit 54 instruction set, bit 55 marks it valid
// - bits 57:56 privilege level, bit 58 marks it valid
// - bit 59 set when the machine check was corrected
// - bit 60 set only when a target address was logged
// - bit 61 set only when a requester id was logged
// - bit 62 set only when a responder id was logged
// - bit 63 set only when a precise pointer was logged
// - argument 1 sets expected resource, 0 clears it
// - no correction attempted while a check is expected
// - expected resource resets to not expected
// - each call returns the resource's previous state
// - each call answers status 0 or -2
`timescale 1ns/1ns
`include "uarch_err_regs.vh"

module uarch_error_record (
    // clock and reset
    input wire clk,
    input wire reset,
    // error report from the failing structure
    input wire err_valid,
    input wire [4:0] struct_code,
    input wire [2:0] struct_level,
    input wire [3:0] array_select_code,
    input wire [3:0] access_kind,
    input wire [5:0] err_way,
    input wire slot_valid,
    input wire [7:0] err_set_index,
    input wire set_index_valid,
    input wire instr_set_flag,
    input wire instr_set_valid,
    input wire [1:0] priv_level,
    input wire priv_level_valid,
    input wire correctable,
    input wire target_addr_logged,
    input wire requester_logged,
    input wire responder_logged,
    input wire precise_ip_logged,
    // expect_flag_call port
    input wire call_valid,
    input wire [63:0] call_arg,
    output wire resp_valid,
    output wire [7:0] resp_status,
    output wire resp_previous,
    // record and handler view
    output reg [63:0] record_q,
    output reg record_valid_q,
    output reg correct_attempt_q,
    output wire expected
);

    reg [63:0] rec_d;

    expect_flag_unit expect_flag_unit_inst (
        .clk(clk),
        .reset(reset),
        .call_valid(call_valid),
        .call_arg(call_arg),
        .resp_valid_q(resp_valid),
        .resp_status_q(resp_status),
        .resp_previous_q(resp_previous),
        .expected_q(expected)
    );

    always @* begin
        rec_d = 64'h0000_0000_0000_0000;
        rec_d[`REC_STRUCT_LSB +: 5] = struct_code;
        rec_d[`REC_LEVEL_LSB +: 3] = struct_level;
        rec_d[`REC_ARRAY_LSB +: 4] = array_select_code;
        rec_d[`REC_OP_LSB +: 4] = access_kind;
        // an unqualified field reads as zero so stale data never leaks
        rec_d[`REC_WAY_LSB +: 6] = slot_valid ? err_way : 6'h00;
        rec_d[`REC_WAY_VALID] = slot_valid;
        rec_d[`REC_SET_LSB +: 8] =
            set_index_valid ? err_set_index : 8'h00;
        rec_d[`REC_SET_VALID] = set_index_valid;
        rec_d[`REC_ISET] = instr_set_valid & instr_set_flag;
        rec_d[`REC_ISET_VALID] = instr_set_valid;
        rec_d[`REC_PRIV_LSB +: 2] =
            priv_level_valid ? priv_level : 2'h0;
        rec_d[`REC_PRIV_VALID] = priv_level_valid;
        // expected checks are left uncorrected
        rec_d[`REC_CORRECTED] = correctable & ~expected;
        rec_d[`REC_TARGET] = target_addr_logged;
        rec_d[`REC_REQUESTER] = requester_logged;
        rec_d[`REC_RESPONDER] = responder_logged;
        rec_d[`REC_PRECISE_IP] = precise_ip_logged;
    end

    always @(posedge clk) begin
        if (reset) begin
            record_q <= 64'h0000_0000_0000_0000;
            record_valid_q <= 1'b0;
            correct_attempt_q <= 1'b0;
        end else begin
            record_valid_q <= err_valid;
            // expected level taken at the error edge, a call lands later
            correct_attempt_q <=
                err_valid & correctable & ~expected;
            if (err_valid) begin
                record_q <= rec_d;
            end
        end
    end

endmodule // uarch_error_record

// file: design/uarch_err_regs.vh
`ifndef UARCH_ERR_REGS_VH
`define UARCH_ERR_REGS_VH

// error record field positions
`define REC_STRUCT_LSB 0
`define REC_LEVEL_LSB 5
`define REC_ARRAY_LSB 8
`define REC_OP_LSB 12
`define REC_WAY_LSB 16
`define REC_WAY_VALID 22
`define REC_SET_VALID 23
`define REC_SET_LSB 32
`define REC_ISET 54
`define REC_ISET_VALID 55
`define REC_PRIV_LSB 56
`define REC_PRIV_VALID 58
`define REC_CORRECTED 59
`define REC_TARGET 60
`define REC_REQUESTER 61
`define REC_RESPONDER 62
`define REC_PRECISE_IP 63

// access kind codes
`define ACCESS_UNKNOWN 4'h0
`define ACCESS_READ 4'h1
`define ACCESS_WRITE 4'h2

// call status codes, 8-bit two's complement
`define STATUS_OK 8'h00
`define STATUS_BAD_ARG 8'hfe
`define STATUS_ERROR 8'hfd

// reset value of the expected resource
`define EXPECT_RESET 1'b0

`endif

// file: design/expect_flag_unit.v
`timescale 1ns/1ns
`include "uarch_err_regs.vh"

module expect_flag_unit (
    // clock and reset
    input wire clk,
    input wire reset,
    // call port
    input wire call_valid,
    input wire [63:0] call_arg,
    output reg resp_valid_q,
    output reg [7:0] resp_status_q,
    output reg resp_previous_q,
    // resource
    output reg expected_q
);

    wire arg_ok;

    assign arg_ok = (call_arg[63:1] == 63'h0);

    always @(posedge clk) begin
        if (reset) begin
            expected_q <= `EXPECT_RESET;
            resp_valid_q <= 1'b0;
            resp_status_q <= `STATUS_OK;
            resp_previous_q <= 1'b0;
        end else begin
            resp_valid_q <= call_valid;
            if (call_valid) begin
                resp_previous_q <= expected_q;
                if (arg_ok) begin
                    expected_q <= call_arg[0];
                    resp_status_q <= `STATUS_OK;
                end else begin
                    // reserved argument leaves the resource alone
                    resp_status_q <= `STATUS_BAD_ARG;
                end
            end
        end
    end

endmodule // expect_flag_unit

// file: tb/uarch_error_record_properties.sv
`timescale 1ns/1ns
module uarch_error_record_properties (
    // watched ports
    input wire clk, reset, err_valid, slot_valid, target_addr_logged,
    input wire call_valid, resp_valid, resp_previous, expected,
    input wire record_valid_q, correct_attempt_q,
    input wire [63:0] call_arg, record_q,
    input wire [7:0] resp_status
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence set_call; call_valid && call_arg == 64'h1; endsequence
    sequence clear_call; call_valid && call_arg == 64'h0; endsequence
    a_record_pulse: assert property (err_valid |=> record_valid_q)
        else $error("record not loaded");
    a_reserved_zero: assert property (record_valid_q |->
        record_q[31:24] == 0 && record_q[53:40] == 0) else $error("reserved");
    a_way_hidden: assert property (err_valid && !slot_valid |=>
        record_q[22:16] == 0) else $error("way shown while invalid");
    a_target_bit: assert property (err_valid |=>
        record_q[60] == $past(target_addr_logged)) else $error("target bit");
    a_no_correct: assert property (err_valid && expected |=>
        !correct_attempt_q && !record_q[59]) else $error("corrected");
    a_set_flag: assert property (set_call |=> resp_valid && expected)
        else $error("flag not set");
    a_clear_flag: assert property (clear_call |=> !expected)
        else $error("flag not cleared");
    a_prev_state: assert property (call_valid |=>
        resp_previous == $past(expected)) else $error("previous wrong");
    a_bad_arg: assert property (call_valid && call_arg > 1 |=>
        resp_status == 8'hfe && $stable(expected)) else $error("bad arg");
endmodule // uarch_error_record_properties
bind uarch_error_record uarch_error_record_properties props_inst (.clk,
    .reset, .err_valid, .slot_valid, .target_addr_logged, .call_valid,
    .resp_valid, .resp_previous, .expected, .record_valid_q,
    .correct_attempt_q, .call_arg, .record_q, .resp_status);

// file: tb/uarch_error_record_tb.sv
`timescale 1ns/1ns
module uarch_error_record_tb;
    reg clk = 0, reset = 1, err_valid = 0, call_valid = 0, exp_q = 0;
    reg [63:0] ef = 0, call_arg = 0;
    wire [63:0] record_q;
    wire [7:0] resp_status;
    wire resp_valid, resp_previous, record_valid_q, correct_attempt_q, expected;
    integer mismatches = 0, total_checks = 0, cycles = 0, i;
    always #5 clk = ~clk;
    uarch_error_record uarch_error_record_inst (.clk, .reset, .err_valid,
        .struct_code(ef[4:0]), .struct_level(ef[7:5]),
        .array_select_code(ef[11:8]), .access_kind(ef[15:12]),
        .err_way(ef[21:16]), .slot_valid(ef[22]), .set_index_valid(ef[23]),
        .err_set_index(ef[39:32]), .instr_set_flag(ef[54]),
        .instr_set_valid(ef[55]), .priv_level(ef[57:56]),
        .priv_level_valid(ef[58]), .correctable(ef[59]),
        .target_addr_logged(ef[60]), .requester_logged(ef[61]),
        .responder_logged(ef[62]), .precise_ip_logged(ef[63]), .call_valid,
        .call_arg, .resp_valid, .resp_status, .resp_previous, .record_q,
        .record_valid_q, .correct_attempt_q, .expected);
    task check(input string what, input [63:0] e, input [63:0] g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task call(input [63:0] a, input [7:0] st);
        @(posedge clk) call_valid <= 1;
        call_arg <= a;
        @(posedge clk) call_valid <= 0;
        #1 check("resp_valid", 1, resp_valid);
        check("resp_status", st, resp_status);
        check("resp_previous", exp_q, resp_previous);
        if (a < 2) exp_q = a[0];
        check("expected", exp_q, expected);
    endtask
    task err(input [63:0] v);
        reg [63:0] r;
        r = v & 64'hffc0_00ff_00ff_ffff; // reserved input bits dropped
        if (!r[22]) r[21:16] = 0;
        if (!r[23]) r[39:32] = 0;
        if (!r[55]) r[54] = 0;
        if (!r[58]) r[57:56] = 0;
        r[59] = v[59] & ~exp_q;
        @(posedge clk) err_valid <= 1;
        ef <= v;
        @(posedge clk) err_valid <= 0;
        #1 check("record_valid_q", 1, record_valid_q);
        check("record_q", r, record_q);
        check("correct_attempt_q", r[59], correct_attempt_q);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 500) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        reset <= 0;
        #1 check("expected", 0, expected);
        call(0, 0);
        call(1, 0);
        call(5, 8'hfe);
        call(0, 0);
        $display("call test done");
        for (i = 0; i < 3; i = i + 1)
            err(64'hffff_ffff_ffff_0fff | (i << 12));
        err(64'h0a00_00a5_3c15_4123);
        call(1, 0);
        err(64'hffff_ffff_ffff_ffff);
        call(0, 0);
        $display("record test done");
        finish_test;
    end
endmodule // uarch_error_record_tb
